// ### iea_core_model.sv
// core-side model: answers finish requests after a set latency
`timescale 1ns/100ps
module iea_core_model (
	input  wire       clk_i,
	input  wire       busy_i,
	input  wire       rx_i,
	input  wire [3:0] lat_i,
	input  wire       finish_req_i,
	output reg        idle_o,
	output reg        rx_o,
	output reg        fin_ack_o
);
reg [3:0] cnt;
initial begin
	idle_o = 1'b1;
	rx_o = 1'b0;
	fin_ack_o = 1'b0;
	cnt = 4'h0;
end
always @(posedge clk_i) begin
	rx_o <= rx_i && busy_i && !fin_ack_o;
	if (!finish_req_i) begin
		fin_ack_o <= 1'b0;
		cnt <= 4'h0;
		idle_o <= !busy_i;
	end else if (cnt == lat_i) begin
		// held until the request drops
		fin_ack_o <= 1'b1;
		idle_o <= 1'b1;
	end else begin
		cnt <= cnt + 4'h1;
	end
end
endmodule

// ### iea_ctrl.v
// enable and transfer cancel control of the i2c controller, wishbone slave
`timescale 1ns/100ps
`include "iea_defines.vh"
module iea_ctrl #(
	parameter clock_type_param = `IEA_CLK_TYPE_ASYNC,
	parameter ADR_W            = 8
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             ce_i,
	input  wire             wb_cyc_i,
	input  wire             wb_stb_i,
	input  wire             wb_we_i,
	input  wire [ADR_W-1:0] wb_adr_i,
	input  wire [3:0]       wb_sel_i,
	input  wire [31:0]      wb_dat_i,
	output wire [31:0]      wb_dat_o,
	output wire             wb_ack_o,
	output wire             irq_o,
	input  wire             i2c_core_clock_i,
	input  wire             core_idle_i,
	input  wire             core_rx_i,
	input  wire             core_finish_ack_i,
	output wire             en_o,
	output wire             finish_req_o,
	output wire             stop_req_o,
	output wire             nack_last_o,
	output wire             tx_flush_o,
	output wire             rx_flush_o
);

	localparam [1:0] ST_OFF    = 2'b00;
	localparam [1:0] ST_RUN    = 2'b01;
	localparam [1:0] ST_CANCEL = 2'b10;
	localparam [1:0] ST_DRAIN  = 2'b11;

	localparam IW = `IEA_INT_WIDTH;

	// synchronised core side levels
	wire       core_clk_s;
	wire       core_idle_s;
	wire       core_rx_s;
	wire       finish_ack_s;

	iea_sync #(
		.WIDTH (4)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   ({i2c_core_clock_i, core_idle_i, core_rx_i,
			core_finish_ack_i}),
		.q_o   ({core_clk_s, core_idle_s, core_rx_s, finish_ack_s})
	);

	reg                      core_clk_prev_reg;
	wire                     core_edge;
	reg [`IEA_EN_EDGES-1:0]  en_pipe_reg;
	reg                      en_eff_reg;
	reg                      en_reg;
	reg                      cancel_reg;
	reg                      master_reg;
	reg [1:0]                state_reg;
	reg [1:0]                state_next;
	reg                      finish_reg;
	reg                      finish_next;
	reg                      stop_reg;
	reg                      stop_next;
	reg                      nack_reg;
	reg                      nack_next;
	reg                      tx_flush_reg;
	reg                      tx_flush_next;
	reg                      rx_flush_reg;
	reg                      rx_flush_next;
	reg                      cancel_done;
	reg                      off_done;
	reg [IW-1:0]             int_reg;
	reg [IW-1:0]             int_next;
	reg [IW-1:0]             mask_reg;
	reg                      irq_reg;
	reg                      ack_reg;
	reg [31:0]               dat_reg;
	reg [31:0]               rd_data;
	reg [IW-1:0]             int_clr;
	wire                     req;
	wire                     wr_fire;
	wire                     rd_fire;
	wire                     cancel_accept;
	wire                     int_hold;

	assign core_edge = core_clk_s & ~core_clk_prev_reg;

	// bus handshake: ack one cycle after the request, write and clear at ack
	assign req     = wb_cyc_i & wb_stb_i;
	assign wr_fire = req & ack_reg & wb_we_i & wb_sel_i[0];
	assign rd_fire = req & ack_reg & ~wb_we_i;

	// uses the enable and mode bits as they stood before this write
	assign cancel_accept = wr_fire & (wb_adr_i == `IEA_ADR_CTRL) &
		wb_dat_i[`IEA_CTRL_CANCEL_BIT] & en_reg & master_reg;

	// status stays readable until the core has gone idle after a disable
	assign int_hold = (state_reg == ST_DRAIN) |
		(~en_reg & (state_reg != ST_OFF));

	always @* begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
		`IEA_ADR_CTRL: begin
			rd_data[`IEA_CTRL_EN_BIT]     = en_reg;
			rd_data[`IEA_CTRL_CANCEL_BIT] = cancel_reg;
			rd_data[`IEA_CTRL_MASTER_BIT] = master_reg;
		end
		`IEA_ADR_STAT: begin
			rd_data[`IEA_STAT_EN_BIT]     = en_eff_reg;
			rd_data[`IEA_STAT_ACTIVE_BIT] = ~core_idle_s;
			rd_data[`IEA_STAT_CANCEL_BIT] = (state_reg == ST_CANCEL);
			rd_data[`IEA_STAT_FLUSH_BIT]  = tx_flush_reg;
		end
		`IEA_ADR_INT_STAT: begin
			rd_data[IW-1:0] = int_reg;
		end
		`IEA_ADR_INT_MASK: begin
			rd_data[IW-1:0] = mask_reg;
		end
		default: begin
			rd_data = 32'h0000_0000;
		end
		endcase
	end

	// shut-down sequencing
	always @* begin
		state_next  = state_reg;
		nack_next   = nack_reg;
		cancel_done = 1'b0;
		off_done    = 1'b0;
		case (state_reg)
		ST_OFF: begin
			if (en_eff_reg) begin
				state_next = ST_RUN;
			end
		end
		ST_RUN: begin
			if (!en_eff_reg) begin
				if (core_idle_s) begin
					state_next = ST_OFF;
					off_done   = 1'b1;
				end else if (!finish_ack_s) begin
					state_next = ST_DRAIN;
					nack_next  = core_rx_s;
				end
			end else if (cancel_reg && !finish_ack_s) begin
				state_next = ST_CANCEL;
			end
		end
		ST_CANCEL: begin
			if (finish_ack_s) begin
				cancel_done = 1'b1;
				if (en_eff_reg) begin
					state_next = ST_RUN;
				end else begin
					state_next = ST_OFF;
					off_done   = 1'b1;
				end
			end
		end
		ST_DRAIN: begin
			if (finish_ack_s) begin
				state_next = ST_OFF;
				off_done   = 1'b1;
				nack_next  = 1'b0;
			end
		end
		default: begin
			state_next = ST_OFF;
		end
		endcase
		finish_next   = (state_next == ST_CANCEL) |
			(state_next == ST_DRAIN);
		stop_next     = finish_next;
		tx_flush_next = (state_next == ST_OFF) | cancel_done;
		rx_flush_next = (state_next == ST_OFF);
	end

	// read clear acts only on bits that the reader actually saw
	always @* begin
		int_clr = {IW{1'b0}};
		if (rd_fire && (wb_adr_i == `IEA_ADR_INT_STAT) && !int_hold) begin
			int_clr = dat_reg[IW-1:0];
		end
		int_next = int_reg & ~int_clr;
		int_next[`IEA_INT_ABANDON_BIT] = int_next[`IEA_INT_ABANDON_BIT] |
			cancel_done;
		int_next[`IEA_INT_OFF_BIT] = int_next[`IEA_INT_OFF_BIT] |
			off_done;
	end

	// enable crossing onto core clock edges
	always @(posedge clk_i) begin
		if (rst_i) begin
			core_clk_prev_reg <= 1'b0;
			en_pipe_reg       <= {`IEA_EN_EDGES{1'b0}};
			en_eff_reg        <= 1'b0;
		end else if (ce_i) begin
			core_clk_prev_reg <= core_clk_s;
			if (clock_type_param == `IEA_CLK_TYPE_ASYNC) begin
				if (core_edge) begin
					en_pipe_reg <= {en_pipe_reg[`IEA_EN_EDGES-2:0],
						en_reg};
				end
				en_eff_reg <= en_pipe_reg[`IEA_EN_EDGES-1];
			end else begin
				en_eff_reg <= en_reg;
			end
		end
	end

	// software registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			en_reg     <= `IEA_CTRL_RST;
			cancel_reg <= `IEA_CTRL_RST;
			master_reg <= `IEA_CTRL_RST;
			mask_reg   <= `IEA_MASK_RST;
		end else if (ce_i) begin
			if (wr_fire && (wb_adr_i == `IEA_ADR_CTRL)) begin
				en_reg     <= wb_dat_i[`IEA_CTRL_EN_BIT];
				master_reg <= wb_dat_i[`IEA_CTRL_MASTER_BIT];
			end
			if (wr_fire && (wb_adr_i == `IEA_ADR_INT_MASK)) begin
				mask_reg <= wb_dat_i[IW-1:0];
			end
			// only hardware clears the cancel bit; a new accept wins
			if (cancel_accept) begin
				cancel_reg <= 1'b1;
			end else if (cancel_done || off_done) begin
				cancel_reg <= 1'b0;
			end
		end
	end

	// sequencer and core-facing outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= ST_OFF;
			finish_reg   <= 1'b0;
			stop_reg     <= 1'b0;
			nack_reg     <= 1'b0;
			tx_flush_reg <= 1'b1;
			rx_flush_reg <= 1'b1;
		end else if (ce_i) begin
			state_reg    <= state_next;
			finish_reg   <= finish_next;
			stop_reg     <= stop_next;
			nack_reg     <= nack_next;
			tx_flush_reg <= tx_flush_next;
			rx_flush_reg <= rx_flush_next;
		end
	end

	// interrupts and bus answer
	always @(posedge clk_i) begin
		if (rst_i) begin
			int_reg <= `IEA_INT_RST;
			irq_reg <= 1'b0;
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			int_reg <= int_next;
			irq_reg <= |(int_next & mask_reg);
			ack_reg <= req & ~ack_reg;
			if (req && !ack_reg && !wb_we_i) begin
				dat_reg <= rd_data;
			end else if (ack_reg) begin
				dat_reg <= 32'h0000_0000;
			end
		end
	end

	assign wb_dat_o     = dat_reg;
	assign wb_ack_o     = ack_reg;
	assign irq_o        = irq_reg;
	assign en_o         = en_eff_reg;
	assign finish_req_o = finish_reg;
	assign stop_req_o   = stop_reg;
	assign nack_last_o  = nack_reg;
	assign tx_flush_o   = tx_flush_reg;
	assign rx_flush_o   = rx_flush_reg;

endmodule

// ### iea_ctrl_props.sv
// concurrent checks on the enable and cancel control ports
`timescale 1ns/100ps
module iea_ctrl_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        core_finish_ack_i,
	input wire        en_o,
	input wire        finish_req_o,
	input wire        stop_req_o,
	input wire        nack_last_o,
	input wire        rx_flush_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
	else $error("bus request not acked");
ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
	else $error("ack longer than one cycle");
dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
	else $error("read data not zero outside ack");
rst_vals_a: assert property ($fell(rst_i) |-> !en_o && !finish_req_o
	&& rx_flush_o) else $error("outputs wrong after reset");
erase_off_a: assert property ((!en_o && !finish_req_o) [*2] |-> rx_flush_o)
	else $error("fifos not erased while off");
stop_finish_a: assert property (stop_req_o == finish_req_o)
	else $error("stop and finish differ");
nack_drain_a: assert property (nack_last_o |-> finish_req_o && !en_o)
	else $error("nack outside a disable drain");
finish_end_a: assert property (finish_req_o && core_finish_ack_i
	|-> ##[1:6] !finish_req_o) else $error("finish not released");
en_delay_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00
	|=> $stable(en_o) [*4]) else $error("enable acted too soon");
endmodule

// ### iea_ctrl_tb_top.sv
// testbench of the enable and transfer cancel control block
`timescale 1ns/100ps
module iea_ctrl_tb_top;
reg         clk_i = 1'b0;
reg         rst_i = 1'b1;
reg         core_clk = 1'b0;
reg         cyc = 1'b0;
reg         we = 1'b0;
reg  [7:0]  adr = 8'h00;
reg  [31:0] dw = 32'h0000_0000;
reg         busy = 1'b0;
reg         rx = 1'b0;
reg  [3:0]  lat = 4'h2;
reg  [31:0] q;
reg  [31:0] r;
wire [31:0] dr;
wire        ack, irq, en, fin, stp, nack, txf, rxf, idle, crx, fack;
integer     errors = 0;
integer     n_checks = 0;
integer     seed = 32'h3697cf15;
integer     i;
always #12.5 clk_i = ~clk_i;
always #100 core_clk = ~core_clk;
iea_ctrl iea_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
	.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
	.wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
	.irq_o(irq), .i2c_core_clock_i(core_clk), .core_idle_i(idle),
	.core_rx_i(crx), .core_finish_ack_i(fack), .en_o(en),
	.finish_req_o(fin), .stop_req_o(stp), .nack_last_o(nack),
	.tx_flush_o(txf), .rx_flush_o(rxf));
iea_core_model iea_core_model_i (.clk_i(clk_i), .busy_i(busy), .rx_i(rx),
	.lat_i(lat), .finish_req_i(fin), .idle_o(idle), .rx_o(crx),
	.fin_ack_o(fack));
function [31:0] ex(input e, input c, input m);
	ex = {29'h0, m, c, e};
endfunction
task chk(input [31:0] s, input [31:0] e);
	begin
		n_checks = n_checks + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	end
endtask
task chkb(input s, input e);
	chk({31'h0, s}, {31'h0, e});
endtask
task bus(input [7:0] a, input w, input [31:0] d);
	begin
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		q = dr;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	end
endtask
task rd(input [7:0] a, input [31:0] e);
	begin
		bus(a, 1'b0, 32'h0000_0000);
		chk(q, e);
	end
endtask
task final_report;
	begin
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
endtask
initial begin
	#400000;
	errors = errors + 1;
	final_report;
end
initial begin
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	@(posedge clk_i);
	rd(8'h00, ex(0, 0, 0));
	rd(8'h10, 32'h0000_0000);
	for (i = 0; i < 4; i = i + 1) begin
		r = $random(seed);
		lat <= r[3:0];
		bus(8'h0C, 1'b1, r);
		rd(8'h0C, r & 32'h0000_0003);
	end
	bus(8'h0C, 1'b1, 32'h0000_0003);
	bus(8'h00, 1'b1, 32'h0000_0006);
	rd(8'h00, ex(0, 0, 1));
	bus(8'h00, 1'b1, 32'h0000_0005);
	for (i = 0; i < 100 && en !== 1'b1; i = i + 1) @(posedge clk_i);
	chkb(i >= 6 && i <= 22, 1'b1);
	@(posedge clk_i);
	chkb(rxf, 1'b0);
	rd(8'h04, 32'h0000_0001);
	busy <= 1'b1;
	lat <= 4'hf;
	bus(8'h00, 1'b1, 32'h0000_0007);
	rd(8'h00, ex(1, 1, 1));
	bus(8'h00, 1'b1, 32'h0000_0005);
	rd(8'h00, ex(1, 1, 1));
	rd(8'h04, 32'h0000_0007);
	for (i = 0; i < 200 && irq !== 1'b1; i = i + 1) @(posedge clk_i);
	chkb(irq, 1'b1);
	chkb(txf, 1'b1);
	chkb(fin, 1'b0);
	chkb(stp, 1'b0);
	rd(8'h00, ex(1, 0, 1));
	rd(8'h08, 32'h0000_0001);
	@(posedge clk_i);
	chkb(irq, 1'b0);
	rx <= 1'b1;
	q = $random(seed);
	lat <= q[3:0];
	bus(8'h00, 1'b1, 32'h0000_0000);
	for (i = 0; i < 200 && nack !== 1'b1; i = i + 1) @(posedge clk_i);
	chkb(nack, 1'b1);
	chkb(fin, 1'b1);
	chkb(stp, 1'b1);
	busy <= 1'b0;
	for (i = 0; i < 200 && rxf !== 1'b1; i = i + 1) @(posedge clk_i);
	chkb(rxf, 1'b1);
	chkb(en, 1'b0);
	chkb(txf, 1'b1);
	rd(8'h08, 32'h0000_0002);
	rst_i <= 1'b1;
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	@(posedge clk_i);
	rd(8'h0C, 32'h0000_0000);
	rd(8'h00, ex(0, 0, 0));
	final_report;
end
endmodule
bind iea_ctrl iea_ctrl_props iea_ctrl_props_i (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
	.core_finish_ack_i, .en_o, .finish_req_o, .stop_req_o, .nack_last_o,
	.rx_flush_o);

// ### iea_defines.vh
// register offsets, field positions, reset values and counts of the control block
`ifndef IEA_DEFINES_VH
`define IEA_DEFINES_VH

// register byte offsets on the bus
`define IEA_ADR_CTRL          8'h00
`define IEA_ADR_STAT          8'h04
`define IEA_ADR_INT_STAT      8'h08
`define IEA_ADR_INT_MASK      8'h0C

// control register fields
`define IEA_CTRL_EN_BIT       0
`define IEA_CTRL_CANCEL_BIT   1
`define IEA_CTRL_MASTER_BIT   2

// status register fields
`define IEA_STAT_EN_BIT       0
`define IEA_STAT_ACTIVE_BIT   1
`define IEA_STAT_CANCEL_BIT   2
`define IEA_STAT_FLUSH_BIT    3

// interrupt status and mask fields
`define IEA_INT_ABANDON_BIT   0
`define IEA_INT_OFF_BIT       1
`define IEA_INT_WIDTH         2

// reset values
`define IEA_CTRL_RST          1'b0
`define IEA_INT_RST           2'h0
`define IEA_MASK_RST          2'h0

// core clock edges between an enable write and its effect
`define IEA_EN_EDGES          2
// clock type: 1 core clock asynchronous, 0 synchronous
`define IEA_CLK_TYPE_ASYNC    1

`endif

// ### iea_sync.v
// two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
module iea_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             ce_i,
	input  wire [WIDTH-1:0] d_i,
	output wire [WIDTH-1:0] q_o
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk_i) begin
				if (rst_i) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
				end else if (ce_i) begin
					meta_reg[i] <= d_i[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	assign q_o = sync_reg;

endmodule
